/* File: ambient_light_sequencer.sv */
// ambient light measurement sequencer with i2c target register port
`include "ambient_light_sequencer_cfg.svh"

module ambient_light_sequencer
  import ambient_light_sequencer_pkg::*;
#(
  parameter int unsigned FRAME_CYC = `FRAME_CYCLES,
  parameter int unsigned CONV_CYC = `CONV_CYCLES
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire ambient_light_sequencer_pkg::result_t als_sample_in,
  input wire ambient_light_sequencer_pkg::result_t prox_sample_in,
  output logic int_out,
  output logic int_oe_n_out,
  output logic [5:0] emitter_current_out,
  output logic [1:0] carrier_sel_out
);
  import ambient_light_sequencer_pkg::*;

  // ---------------- system clock domain: pin sync and start/stop detection
  logic rst_link_q;
  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;
  logic [2:0] tog_sync_q;
  logic scl_v_q;
  logic sda_v_q;
  logic tog_v_q;
  logic start_tog_q;
  logic busy_q;
  // flips on every register write; driven by the link domain below
  logic cfg_tog_q;

  // a change counts only once the second and third stages agree
  wire scl_v_d = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2] : scl_v_q;
  wire sda_v_d = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_v_q;
  wire tog_v_d = (tog_sync_q[1] == tog_sync_q[2]) ? tog_sync_q[2] : tog_v_q;
  wire start_det = scl_v_q & scl_v_d & sda_v_q & ~sda_v_d;
  wire stop_det = scl_v_q & scl_v_d & ~sda_v_q & sda_v_d;
  wire cfg_upd = tog_v_d != tog_v_q;

  always_ff @(posedge clock_in) begin
    rst_link_q <= rst_in;
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      tog_sync_q <= 3'h0;
      scl_v_q <= 1'b1;
      sda_v_q <= 1'b1;
      tog_v_q <= 1'b0;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      sda_sync_q <= {sda_sync_q[1:0], sda_in};
      tog_sync_q <= {tog_sync_q[1:0], cfg_tog_q};
      scl_v_q <= scl_v_d;
      sda_v_q <= sda_v_d;
      tog_v_q <= tog_v_d;
    end
  end

  // a start of either kind begins a fresh transaction
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      start_tog_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      start_tog_q <= start_tog_q ^ start_det;
      busy_q <= start_det | (busy_q & ~stop_det);
    end
  end

  // ---------------- link domain: byte engine on the host's clock
  link_phase_e phase_q, phase_d;
  logic [3:0] cnt_q;
  byte_t shift_q;
  byte_t ptr_q, ptr_d;
  byte_t tx_q, tx_d;
  logic seen_tog_q;
  logic wr_en;
  byte_t led_w_q;
  byte_t als_w_q;
  byte_t mod_w_q;
  byte_t inten_w_q;
  byte_t clr_w_q;
  logic sda_oe_n_q;
  logic sda_out_q;
  result_t snap_res_q;
  result_t snap_prox_q;
  logic [1:0] snap_stat_q;

  // start toggle settles during the start hold time, before the first rise
  wire new_frame = start_tog_q != seen_tog_q;
  wire byte_end = cnt_q == 4'h8;
  wire addr_hit = shift_q[7:1] == `DEV_ADDR;
  wire [3:0] cnt_d = new_frame ? 4'h1 : (byte_end ? 4'h0 : cnt_q + 4'h1);
  wire [7:0] shift_d = new_frame ? {7'h00, sda_in} :
                       (byte_end ? shift_q : {shift_q[6:0], sda_in});
  // snapshots hold still while a transaction runs, so both bytes match
  wire [7:0] rd_data =
      (ptr_q == `REG_LED) ? led_w_q :
      (ptr_q == `REG_ALS) ? als_w_q :
      (ptr_q == `REG_RES_HI) ? snap_res_q[15:8] :
      (ptr_q == `REG_RES_LO) ? snap_res_q[7:0] :
      (ptr_q == `REG_PROX_HI) ? snap_prox_q[15:8] :
      (ptr_q == `REG_PROX_LO) ? snap_prox_q[7:0] :
      (ptr_q == `REG_INTEN) ? inten_w_q :
      (ptr_q == `REG_STATUS) ? {6'h00, snap_stat_q} :
      (ptr_q == `REG_MOD) ? mod_w_q : 8'h00;
  wire ack_drive = byte_end & ((phase_q == LINK_ADDR & addr_hit) |
                   phase_q == LINK_INDEX | phase_q == LINK_WDATA);
  wire data_drive = (phase_q == LINK_READ) & ~cnt_q[3] & ~tx_q[~cnt_q[2:0]];

  always_comb begin
    phase_d = phase_q;
    ptr_d = ptr_q;
    tx_d = tx_q;
    wr_en = 1'b0;
    if (new_frame) begin
      phase_d = LINK_ADDR;
    end else if (byte_end) begin
      unique case (phase_q)
        LINK_ADDR: begin
          if (!addr_hit) begin
            phase_d = LINK_IDLE;
          end else if (shift_q[0]) begin
            phase_d = LINK_READ;
            tx_d = rd_data;
            ptr_d = ptr_q + 8'h01;
          end else begin
            phase_d = LINK_INDEX;
          end
        end
        LINK_INDEX: begin
          ptr_d = shift_q;
          phase_d = LINK_WDATA;
        end
        LINK_WDATA: begin
          wr_en = 1'b1;
          ptr_d = ptr_q + 8'h01;
        end
        LINK_READ: begin
          if (!sda_in) begin
            tx_d = rd_data;
            ptr_d = ptr_q + 8'h01;
          end else begin
            phase_d = LINK_IDLE;
          end
        end
        LINK_IDLE: begin
        end
        default: begin
          phase_d = LINK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge scl_in or posedge rst_link_q) begin
    if (rst_link_q) begin
      phase_q <= LINK_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      tx_q <= 8'h00;
      seen_tog_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      ptr_q <= ptr_d;
      tx_q <= tx_d;
      seen_tog_q <= start_tog_q;
    end
  end

  always_ff @(posedge scl_in or posedge rst_link_q) begin
    if (rst_link_q) begin
      led_w_q <= `LED_RST;
      als_w_q <= `ALS_RST;
      mod_w_q <= `MOD_RST;
      inten_w_q <= `INTEN_RST;
      clr_w_q <= 8'h00;
      cfg_tog_q <= 1'b0;
    end else if (wr_en) begin
      led_w_q <= (ptr_q == `REG_LED) ? shift_q : led_w_q;
      als_w_q <= (ptr_q == `REG_ALS) ? shift_q : als_w_q;
      mod_w_q <= (ptr_q == `REG_MOD) ? shift_q : mod_w_q;
      inten_w_q <= (ptr_q == `REG_INTEN) ? shift_q : inten_w_q;
      clr_w_q <= (ptr_q == `REG_STATUS) ? shift_q : 8'h00;
      cfg_tog_q <= ~cfg_tog_q;
    end
  end

  // data changes on the falling edge, well clear of the host's sampling
  always_ff @(negedge scl_in or posedge rst_link_q) begin
    if (rst_link_q) begin
      sda_oe_n_q <= 1'b1;
      sda_out_q <= 1'b0;
    end else begin
      sda_oe_n_q <= ~(ack_drive | data_drive);
      sda_out_q <= 1'b0;
    end
  end

  // ---------------- system clock domain: configuration and measurement
  logic [5:0] led_code_q;
  byte_t als_cfg_q;
  logic [1:0] carrier_q;
  logic [1:0] inten_q;
  logic [1:0] status_q;
  logic int_oe_n_q;
  meas_state_e meas_q, meas_d;
  logic [15:0] conv_cnt_q;
  logic [23:0] frame_cnt_q;
  byte_t nsamp_q;
  logic [22:0] sum_q;
  result_t res_q;
  result_t prox_res_q;

  wire [5:0] led_raw = led_w_q[5:0];
  // out-of-range codes pinned to the nearest legal step
  wire [5:0] led_clamp = (led_raw < `LED_MIN) ? `LED_MIN :
                         ((led_raw > `LED_MAX) ? `LED_MAX : led_raw);
  wire cont = als_cfg_q[`ALS_CONT_BIT];
  wire [2:0] avg_code = als_cfg_q[2:0];
  wire [7:0] avg_n = 8'h01 << avg_code;
  wire conv_done = (meas_q == MEAS_CONV) && (conv_cnt_q == 16'(CONV_CYC - 1));
  // at-or-past, so a smaller count written mid-cycle cannot stall publishing
  wire last_samp = (nsamp_q + 8'h01) >= avg_n;
  wire frame_end = ~cont && (frame_cnt_q == 24'(FRAME_CYC - 1));
  wire publish = cont ? (conv_done & last_samp) : frame_end;
  wire [22:0] acc_next = sum_q + (conv_done ? {7'h00, als_sample_in} : 23'h00_0000);
  wire [22:0] avg_full = acc_next >> avg_code;
  wire [15:0] res_d = avg_full[15:0];
  wire [1:0] stat_set = publish ? {prox_sample_in != prox_res_q, res_d != res_q} : 2'h0;

  always_comb begin
    meas_d = meas_q;
    if (cont) begin
      meas_d = MEAS_CONV;
    end else if (frame_end) begin
      meas_d = MEAS_CONV;
    end else if (conv_done && last_samp) begin
      meas_d = MEAS_WAIT;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      led_code_q <= 6'(`LED_RST);
      als_cfg_q <= `ALS_RST;
      carrier_q <= 2'h0;
      inten_q <= 2'h0;
    end else if (cfg_upd) begin
      led_code_q <= led_clamp;
      als_cfg_q <= als_w_q;
      carrier_q <= mod_w_q[`FREQ_LSB+1:`FREQ_LSB];
      inten_q <= inten_w_q[1:0];
    end
  end

  // a new event wins over a clear landing in the same cycle
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      status_q <= 2'h0;
      int_oe_n_q <= 1'b1;
    end else begin
      status_q <= (status_q & ~(cfg_upd ? clr_w_q[1:0] : 2'h0)) | stat_set;
      int_oe_n_q <= ~|(status_q & inten_q);
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      meas_q <= MEAS_CONV;
      conv_cnt_q <= 16'h0000;
      frame_cnt_q <= 24'h00_0000;
      nsamp_q <= 8'h00;
      sum_q <= 23'h00_0000;
    end else begin
      meas_q <= meas_d;
      conv_cnt_q <= (conv_done || frame_end || meas_q != MEAS_CONV) ? 16'h0000 :
                    conv_cnt_q + 16'h0001;
      frame_cnt_q <= (cont || frame_end) ? 24'h00_0000 : frame_cnt_q + 24'h00_0001;
      nsamp_q <= publish ? 8'h00 : (conv_done ? nsamp_q + 8'h01 : nsamp_q);
      sum_q <= publish ? 23'h00_0000 : acc_next;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      res_q <= 16'h0000;
      prox_res_q <= 16'h0000;
    end else if (publish) begin
      res_q <= res_d;
      prox_res_q <= prox_sample_in;
    end
  end

  // copies only move while the bus is quiet, so the link sees stable words
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      snap_res_q <= 16'h0000;
      snap_prox_q <= 16'h0000;
      snap_stat_q <= 2'h0;
    end else if (!busy_q) begin
      snap_res_q <= res_q;
      snap_prox_q <= prox_res_q;
      snap_stat_q <= status_q;
    end
  end

  assign sda_out = sda_out_q;
  assign sda_oe_n_out = sda_oe_n_q;
  assign int_out = 1'b0 & int_oe_n_q;
  assign int_oe_n_out = int_oe_n_q;
  assign emitter_current_out = led_code_q;
  assign carrier_sel_out = carrier_q;

  // ---------------- checks
  a_std_frame_end: assert property (@(posedge clock_in) disable iff (rst_in)
    (publish && !cont) |-> (frame_cnt_q == 24'(FRAME_CYC - 1)))
    else $error("framed result published off the frame boundary");
  a_conv_length: assert property (@(posedge clock_in) disable iff (rst_in)
    conv_done |-> (meas_q == MEAS_CONV && conv_cnt_q == 16'(CONV_CYC - 1)))
    else $error("conversion ended at wrong count");
  a_cont_no_gap: assert property (@(posedge clock_in) disable iff (rst_in)
    (conv_done && cont && $stable(als_cfg_q)) |=> (meas_q == MEAS_CONV && conv_cnt_q == 16'h0000))
    else $error("gap between continuous conversions");
  a_std_idle_rest: assert property (@(posedge clock_in) disable iff (rst_in)
    (conv_done && last_samp && !cont && !frame_end) |=> (meas_q == MEAS_WAIT || cont))
    else $error("framed mode did not idle after last conversion");
  a_avg_result: assert property (@(posedge clock_in) disable iff (rst_in)
    publish |=> (res_q == $past(res_d)) && (sum_q == 23'h00_0000) && (nsamp_q == 8'h00))
    else $error("averaged result not taken at publish");
  a_result_hold: assert property (@(posedge clock_in) disable iff (rst_in)
    !$past(publish) |-> $stable(res_q) && $stable(prox_res_q))
    else $error("result changed without a finished cycle");
  a_led_range: assert property (@(posedge clock_in) disable iff (rst_in)
    (led_code_q >= `LED_MIN) && (led_code_q <= `LED_MAX))
    else $error("emitter current code out of range");
  a_int_follows: assert property (@(posedge clock_in) disable iff (rst_in)
    (|(status_q & inten_q)) |=> !int_oe_n_out)
    else $error("interrupt pin not asserted for pending event");
  a_ptr_advance: assert property (@(posedge scl_in) disable iff (rst_link_q)
    (byte_end && !new_frame && phase_q == LINK_READ && !sda_in) |=> (ptr_q == $past(ptr_q) + 8'h01))
    else $error("register pointer did not advance after read");
endmodule

/* File: ambient_light_sequencer_cfg.svh */
// constants for the ambient light sequencer: addresses, fields, reset values, timing
`ifndef AMBIENT_LIGHT_SEQUENCER_CFG_SVH
`define AMBIENT_LIGHT_SEQUENCER_CFG_SVH

`define CLK_MHZ 100
`define FRAME_MS 100
`define CONV_US 300
`define FRAME_CYCLES (`FRAME_MS * 1000 * `CLK_MHZ)
`define CONV_CYCLES (`CONV_US * `CLK_MHZ)

`define DEV_ADDR 7'h13
`define REG_LED 8'h83
`define REG_ALS 8'h84
`define REG_RES_HI 8'h85
`define REG_RES_LO 8'h86
`define REG_PROX_HI 8'h87
`define REG_PROX_LO 8'h88
`define REG_INTEN 8'h89
`define REG_STATUS 8'h8e
`define REG_MOD 8'h8f

`define LED_RST 8'h02
`define LED_MIN 6'h01
`define LED_MAX 6'h14
`define ALS_RST 8'h05
`define ALS_CONT_BIT 7
`define MOD_RST 8'h01
`define FREQ_LSB 3
`define INTEN_RST 8'h00

`endif

/* File: ambient_light_sequencer_pkg.sv */
// types shared by the ambient light sequencer
package ambient_light_sequencer_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [15:0] result_t;
  typedef enum logic [2:0] {
    LINK_IDLE = 3'b000,
    LINK_ADDR = 3'b001,
    LINK_INDEX = 3'b010,
    LINK_WDATA = 3'b011,
    LINK_READ = 3'b100
  } link_phase_e;
  typedef enum logic {
    MEAS_CONV = 1'b0,
    MEAS_WAIT = 1'b1
  } meas_state_e;
endpackage

/* File: host_model.sv */
// host-side i2c controller model: drives the link clock and pulls the data wire
module host_model (
  output logic scl_out,
  output logic sda_oe_n_out,
  input wire logic sda_in
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime HALF = 62.5;
  initial begin
    scl_out = 1'b1;
    sda_oe_n_out = 1'b1;
  end
  // data moves 20 ns after scl falls so the device's sync never sees both edges at once
  task automatic start();
    #20;
    sda_oe_n_out = 1'b1;
    #(HALF);
    scl_out = 1'b1;
    #(HALF);
    sda_oe_n_out = 1'b0;
    #(HALF + 20);
    scl_out = 1'b0;
  endtask
  task automatic stop();
    #20;
    sda_oe_n_out = 1'b0;
    #(HALF);
    scl_out = 1'b1;
    #(HALF);
    sda_oe_n_out = 1'b1;
    #(4 * HALF);
  endtask
  task automatic bit_io(input logic b, output logic s);
    #20;
    sda_oe_n_out = b;
    #(HALF - 20);
    scl_out = 1'b1;
    #(HALF / 2);
    s = sda_in;
    #(HALF / 2);
    scl_out = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s); // nack on the last byte ends the read
  endtask
endmodule

/* File: testbench.sv */
// self-checking bench for the ambient light sequencer over its i2c port
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import ambient_light_sequencer_pkg::*;
  localparam int unsigned CONV = 20;
  localparam int unsigned FRAME = 3000;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic scl;
  logic host_oe_n;
  logic dev_sda;
  logic dev_oe_n;
  logic int_v;
  logic int_oe_n;
  logic [5:0] cur;
  logic [1:0] car;
  result_t als = 16'h0555;
  result_t prox = 16'hbeef;
  wire sda;
  int fail_count = 0;
  int n_compared = 0;
  // open-drain wire with pull-up
  assign sda = host_oe_n & (dev_oe_n | dev_sda);
  always #5 clock_in = ~clock_in;
  host_model host_model_i (
    .scl_out(scl),
    .sda_oe_n_out(host_oe_n),
    .sda_in(sda)
  );
  ambient_light_sequencer #(
    .FRAME_CYC(FRAME),
    .CONV_CYC(CONV)
  ) ambient_light_sequencer_i (
    .clock_in(clock_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
    .sda_out(dev_sda), .sda_oe_n_out(dev_oe_n), .als_sample_in(als),
    .prox_sample_in(prox), .int_out(int_v), .int_oe_n_out(int_oe_n),
    .emitter_current_out(cur), .carrier_sel_out(car)
  );
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic settle();
    repeat (10) @(posedge clock_in);
  endtask
  task automatic send(input byte_t b);
    logic a;
    host_model_i.wbyte(b, a);
    check({15'h0000, a}, 16'h0001);
  endtask
  // index write with no data byte; keep the bus for a repeated start if asked
  task automatic set_idx(input byte_t idx, input logic rs);
    host_model_i.start();
    send(8'h26);
    send(idx);
    if (!rs) begin
      host_model_i.stop();
    end
  endtask
  task automatic wr_reg(input byte_t idx, input byte_t d);
    set_idx(idx, 1'b1);
    send(d);
    host_model_i.stop();
  endtask
  task automatic rd(input int n, output logic [15:0] v);
    byte_t d;
    v = 16'h0000;
    host_model_i.start();
    send(8'h27);
    for (int i = 0; i < n; i++) begin
      host_model_i.rbyte(i == n - 1, d);
      v = {v[7:0], d};
    end
    host_model_i.stop();
  endtask
  task automatic wait_int(output time t);
    int n;
    n = 0;
    while (int_oe_n !== 1'b0 && n < 3 * FRAME) begin
      @(negedge clock_in);
      n++;
    end
    check({15'h0000, int_oe_n}, 16'h0000);
    check({15'h0000, int_v}, 16'h0000);
    t = $time;
  endtask
  initial begin
    byte_t leds[2] = '{8'h01, 8'h14};
    time t1;
    time t2;
    logic [15:0] v;
    repeat (6) @(posedge clock_in);
    rst_in <= 1'b0;
    settle();
    check({10'h000, cur}, 16'h0002);
    check({14'h0000, car}, 16'h0000);
    foreach (leds[i]) begin
      wr_reg(8'h83, leds[i]);
      settle();
      check({10'h000, cur}, {8'h00, leds[i]});
    end
    for (int f = 0; f < 4; f++) begin
      wr_reg(8'h8f, byte_t'(f << 3));
      settle();
      check({14'h0000, car}, 16'(f));
    end
    wr_reg(8'h89, 8'h01);
    wr_reg(8'h84, 8'h01);
    @(posedge clock_in);
    als <= 16'h0abc;
    wr_reg(8'h8e, 8'h01);
    wait_int(t1);
    // the two conversions of the next frame see different samples
    @(posedge clock_in);
    als <= 16'h1000;
    repeat (CONV + CONV / 2) @(posedge clock_in);
    als <= 16'h3000;
    wr_reg(8'h8e, 8'h01);
    settle();
    check({15'h0000, int_oe_n}, 16'h0001);
    wait_int(t2);
    check(16'((t2 - t1) / 10), 16'(FRAME));
    @(posedge clock_in);
    als <= 16'h0abc;
    wr_reg(8'h8e, 8'h01);
    set_idx(8'h85, 1'b1);
    rd(2, v);
    check(v, 16'h2000);
    wait_int(t1);
    set_idx(8'h85, 1'b0);
    rd(1, v);
    check(v, 16'h000a);
    rd(1, v);
    check(v, 16'h00bc);
    set_idx(8'h87, 1'b1);
    rd(2, v);
    check(v, 16'hbeef);
    wr_reg(8'h84, 8'h80);
    @(posedge clock_in);
    als <= 16'h7e01;
    repeat (10 * CONV) @(posedge clock_in);
    set_idx(8'h85, 1'b1);
    rd(2, v);
    check(v, 16'h7e01);
    stop_test();
  end
  // whole run is a few frames; far beyond that means a hang
  initial begin
    #1000000;
    $display("watchdog expired at %0t", $time);
    fail_count++;
    stop_test();
  end
endmodule
